// file: inc/tmc_regs.vh
// Operation
// - Bits 7, 6, 5 hold pending flags for channels 2, 1, 0; write zero clears.
// - Overflow flag bit 4 sets at terminal count, or at zero turnaround in up/down.
// - Divider bits 3:2 pick tick divided by 1, 8, 32 or 128.
// - Writing the divider never resets the running prescaler counter.
// - Mode 00 suspends counting and holds the counter value.
// - Mode 01 counts 0x0000 to 0xffff and wraps, forever.
// - Mode 10 counts from zero up to the channel 0 value, then restarts.
// - Mode 11 counts up to the channel 0 value then back down to zero.
// - Capture source bit 7 picks normal input or masked radio events.
// - Channel 0 interrupt mask bit 6 enables its interrupt; resets to one.
// - On compare match, action 000 sets, 001 clears, 010 toggles the output.
// - Action 011 sets up/clears at zero or down; 100 opposite; 101-111 reserved.
// - Channel 0 mode bit 2: zero is capture, one is compare.
// - Capture edge bits 1:0: none, rising, falling, both.
// - Flags set on events regardless of masks; processor flag needs mask set.
// - Any write to the counter low byte clears the whole counter.
`ifndef TMC_REGS_VH
`define TMC_REGS_VH

// ==========================================================================
// register indices (byte address is four times the index)
`define TMC_IDX_CC0_LO 8'hda
`define TMC_IDX_CC0_HI 8'hdb
`define TMC_IDX_CNT_LO 8'he2
`define TMC_IDX_CNT_HI 8'he3
`define TMC_IDX_CTL 8'he4
`define TMC_IDX_CCTL0 8'he5
`define TMC_IDX_RFMASK 8'hf0
`define TMC_IDX_IRQ_STAT 8'hf1
`define TMC_IDX_IRQ_MASK 8'hf2

// ==========================================================================
// timer_control_status fields
`define TMC_CTL_CH2 7
`define TMC_CTL_CH1 6
`define TMC_CTL_CH0 5
`define TMC_CTL_OVF 4
`define TMC_CTL_DIV_HI 3
`define TMC_CTL_DIV_LO 2
`define TMC_CTL_MODE_HI 1
`define TMC_CTL_MODE_LO 0
`define TMC_CTL_RESET 8'h00

// ==========================================================================
// channel0_capcmp_control fields
`define TMC_CC_SRC 7
`define TMC_CC_IM 6
`define TMC_CC_ACT_HI 5
`define TMC_CC_ACT_LO 3
`define TMC_CC_CMPMODE 2
`define TMC_CC_EDGE_HI 1
`define TMC_CC_EDGE_LO 0
`define TMC_CCTL0_RESET 8'h40

// ==========================================================================
// encodings
`define TMC_MODE_STOP 2'h0
`define TMC_MODE_FREE 2'h1
`define TMC_MODE_MOD 2'h2
`define TMC_MODE_UPDN 2'h3
`define TMC_DIV_1 2'h0
`define TMC_DIV_8 2'h1
`define TMC_DIV_32 2'h2
`define TMC_DIV_128 2'h3
`define TMC_ACT_SET 3'h0
`define TMC_ACT_CLR 3'h1
`define TMC_ACT_TGL 3'h2
`define TMC_ACT_SETUP 3'h3
`define TMC_ACT_CLRUP 3'h4
`define TMC_EDGE_NONE 2'h0
`define TMC_EDGE_RISE 2'h1
`define TMC_EDGE_FALL 2'h2
`define TMC_EDGE_BOTH 2'h3

// ==========================================================================
// reset values and limits
`define TMC_CNT_MAX 16'hffff
`define TMC_CNT_ZERO 16'h0000
`define TMC_RFMASK_RESET 8'h00
`define TMC_IRQ_MASK_RESET 2'h3
`define TMC_PRE_RESET 7'h00

`endif

// file: hdl/tmc_sync.v
`timescale 1ns/1ps
// ==========================================================================
// three-stage synchroniser with agreement filter and edge pulses
module tmc_sync (
  input wire clk, // core clock
  input wire rst, // async reset, active high
  input wire din, // asynchronous pin level
  output reg level, // filtered level
  output reg rise, // one-cycle pulse on accepted rising change
  output reg fall // one-cycle pulse on accepted falling change
);
  reg s1;
  reg s2;
  reg s3;

  // s1 feeds only s2; decisions look at s2 and s3
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      rise <= 1'b0;
      fall <= 1'b0;
      if (s2 == s3 && s3 != level) begin
        level <= s3;
        rise <= s3;
        fall <= ~s3;
      end
    end
  end
endmodule // tmc_sync

// file: hdl/tmc_presc.v
`timescale 1ns/1ps
`include "tmc_regs.vh"
// ==========================================================================
// free-running tick prescaler; the divider choice only picks the tap
module tmc_presc (
  input wire clk, // core clock
  input wire rst, // async reset, active high
  input wire tick, // timer tick strobe
  input wire [1:0] div, // divider select
  output reg adv // one-cycle counter advance strobe
);
  reg [6:0] pre;
  reg hit;

  always @* begin
    case (div)
      `TMC_DIV_1: hit = 1'b1;
      `TMC_DIV_8: hit = &pre[2:0];
      `TMC_DIV_32: hit = &pre[4:0];
      default: hit = &pre;
    endcase
  end

  // pre is never cleared by a divider write, so a new ratio lines up late
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pre <= `TMC_PRE_RESET;
      adv <= 1'b0;
    end else begin
      if (tick)
        pre <= pre + 7'h01;
      adv <= tick & hit;
    end
  end
endmodule // tmc_presc

// file: hdl/tmc_top.v
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ps
`include "tmc_regs.vh"
// ==========================================================================
// timer control, status and channel 0 capture/compare
module tmc_top (
  input wire CORE_CLK, // 10 MHz core clock
  input wire RESET, // async reset, active high
  input wire WB_CYC_I, // wishbone cycle
  input wire WB_STB_I, // wishbone strobe
  input wire WB_WE_I, // wishbone write enable
  input wire [9:0] WB_ADR_I, // byte address
  input wire [3:0] WB_SEL_I, // byte lanes
  input wire [31:0] WB_DAT_I, // write data
  output reg [31:0] WB_DAT_O, // read data
  output reg WB_ACK_O, // wishbone acknowledge
  input wire TICK, // timer tick strobe, core domain
  input wire CAPTURE_IN, // channel 0 capture pin, asynchronous
  input wire [7:0] RADIO_EVENTS, // radio event pulses, core domain
  input wire [1:0] CHAN_EVENTS, // channel 2,1 event pulses, core domain
  output reg CH0_OUT, // channel 0 compare output
  output reg CPU_TIMER_IRQ_FLAG // level interrupt
);
  // ========================================================================
  // registers
  reg [7:0] ctl;
  reg [7:0] cctl0;
  reg [15:0] cnt;
  reg [15:0] cc0;
  reg [7:0] cnt_hi_buf;
  reg [7:0] rfmask;
  reg [1:0] irq_stat;
  reg [1:0] irq_mask;
  reg dir_down;

  wire [1:0] mode = ctl[`TMC_CTL_MODE_HI:`TMC_CTL_MODE_LO];
  wire [1:0] div = ctl[`TMC_CTL_DIV_HI:`TMC_CTL_DIV_LO];
  wire [2:0] act = cctl0[`TMC_CC_ACT_HI:`TMC_CC_ACT_LO];
  wire [1:0] edge_sel = cctl0[`TMC_CC_EDGE_HI:`TMC_CC_EDGE_LO];
  wire cmp_mode = cctl0[`TMC_CC_CMPMODE];

  // ========================================================================
  // bus decode
  wire [7:0] idx = WB_ADR_I[9:2];
  wire req = WB_CYC_I & WB_STB_I;
  wire wr = req & WB_ACK_O & WB_WE_I & WB_SEL_I[0];
  wire rd_issue = req & ~WB_ACK_O & ~WB_WE_I;
  wire [7:0] wd = WB_DAT_I[7:0];
  wire wr_ctl = wr && idx == `TMC_IDX_CTL;
  wire wr_cnt_lo = wr && idx == `TMC_IDX_CNT_LO;
  wire wr_irq_stat = wr && idx == `TMC_IDX_IRQ_STAT;

  // ========================================================================
  // prescaler and capture input
  wire adv;
  wire cap_rise;
  wire cap_fall;

  tmc_presc u_presc (
    .clk(CORE_CLK),
    .rst(RESET),
    .tick(TICK),
    .div(div),
    .adv(adv)
  );

  tmc_sync u_sync (
    .clk(CORE_CLK),
    .rst(RESET),
    .din(CAPTURE_IN),
    .level(),
    .rise(cap_rise),
    .fall(cap_fall)
  );

  // ========================================================================
  // capture trigger
  reg pin_evt;
  always @* begin
    case (edge_sel)
      `TMC_EDGE_RISE: pin_evt = cap_rise;
      `TMC_EDGE_FALL: pin_evt = cap_fall;
      `TMC_EDGE_BOTH: pin_evt = cap_rise | cap_fall;
      default: pin_evt = 1'b0;
    endcase
  end

  wire radio_evt = |(RADIO_EVENTS & rfmask);
  // radio triggers still need a capture edge selection other than none
  wire src_evt = cctl0[`TMC_CC_SRC] ? (radio_evt && edge_sel != `TMC_EDGE_NONE)
                                    : pin_evt;
  wire cap_evt = ~cmp_mode & src_evt;

  // ========================================================================
  // counter sequencing
  reg [15:0] next_cnt;
  reg next_dir_down;
  reg ovf_evt;
  reg zero_turn;

  always @* begin
    next_cnt = cnt;
    next_dir_down = dir_down;
    ovf_evt = 1'b0;
    zero_turn = 1'b0;
    if (adv) begin
      case (mode)
        `TMC_MODE_FREE: begin
          next_cnt = cnt + 16'h0001;
          ovf_evt = (cnt == `TMC_CNT_MAX);
        end
        `TMC_MODE_MOD: begin
          if (cnt >= cc0) begin
            next_cnt = `TMC_CNT_ZERO;
            ovf_evt = 1'b1;
          end else begin
            next_cnt = cnt + 16'h0001;
          end
        end
        `TMC_MODE_UPDN: begin
          if (!dir_down) begin
            if (cnt >= cc0) begin
              next_dir_down = (cc0 != `TMC_CNT_ZERO);
              next_cnt = (cc0 != `TMC_CNT_ZERO) ? cnt - 16'h0001 : `TMC_CNT_ZERO;
              if (cc0 == `TMC_CNT_ZERO) begin
                ovf_evt = 1'b1;
                zero_turn = 1'b1;
              end
            end else begin
              next_cnt = cnt + 16'h0001;
            end
          end else if (cnt == `TMC_CNT_ZERO) begin
            next_dir_down = 1'b0;
            next_cnt = 16'h0001;
            ovf_evt = 1'b1;
            zero_turn = 1'b1;
          end else begin
            next_cnt = cnt - 16'h0001;
          end
        end
        default: next_cnt = cnt;
      endcase
    end
    if (wr_cnt_lo) begin
      next_cnt = `TMC_CNT_ZERO;
      next_dir_down = 1'b0;
    end
  end

  // ========================================================================
  // compare events and output action
  wire counting = adv && mode != `TMC_MODE_STOP;
  wire eq = counting && cnt == cc0;
  wire at_zero = counting && cnt == `TMC_CNT_ZERO;
  wire eq_up = eq & ~dir_down;
  wire eq_down = eq & dir_down;
  wire updn = (mode == `TMC_MODE_UPDN);
  // in up/down compare mode channel 0 reports the zero turnaround instead
  wire cmp_evt = cmp_mode & (updn ? zero_turn : eq);
  wire ch0_evt = cap_evt | cmp_evt;

  reg next_out;
  always @* begin
    next_out = CH0_OUT;
    if (cmp_mode) begin
      case (act)
        `TMC_ACT_SET: if (eq) next_out = 1'b1;
        `TMC_ACT_CLR: if (eq) next_out = 1'b0;
        `TMC_ACT_TGL: if (eq) next_out = ~CH0_OUT;
        `TMC_ACT_SETUP: begin
          if (eq_up) next_out = 1'b1;
          else if (updn ? eq_down : at_zero) next_out = 1'b0;
        end
        `TMC_ACT_CLRUP: begin
          if (eq_up) next_out = 1'b0;
          else if (updn ? eq_down : at_zero) next_out = 1'b1;
        end
        default: next_out = CH0_OUT;
      endcase
    end
  end

  // ========================================================================
  // control, status and value registers
  always @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      ctl <= `TMC_CTL_RESET;
      cctl0 <= `TMC_CCTL0_RESET;
      cnt <= `TMC_CNT_ZERO;
      cc0 <= `TMC_CNT_ZERO;
      cnt_hi_buf <= 8'h00;
      rfmask <= `TMC_RFMASK_RESET;
      irq_stat <= 2'h0;
      irq_mask <= `TMC_IRQ_MASK_RESET;
      dir_down <= 1'b0;
      CH0_OUT <= 1'b0;
    end else begin
      cnt <= next_cnt;
      dir_down <= next_dir_down;
      CH0_OUT <= next_out;
      if (wr_ctl) begin
        ctl[3:0] <= wd[3:0];
        ctl[7:4] <= ctl[7:4] & wd[7:4];
      end
      // hardware sets win over a simultaneous software clear
      if (CHAN_EVENTS[1]) ctl[`TMC_CTL_CH2] <= 1'b1;
      if (CHAN_EVENTS[0]) ctl[`TMC_CTL_CH1] <= 1'b1;
      if (ch0_evt) ctl[`TMC_CTL_CH0] <= 1'b1;
      if (ovf_evt) ctl[`TMC_CTL_OVF] <= 1'b1;
      if (wr && idx == `TMC_IDX_CCTL0) cctl0 <= wd;
      if (wr && idx == `TMC_IDX_RFMASK) rfmask <= wd;
      if (wr && idx == `TMC_IDX_IRQ_MASK) irq_mask <= wd[1:0];
      if (wr && idx == `TMC_IDX_CC0_LO) cc0[7:0] <= wd;
      if (wr && idx == `TMC_IDX_CC0_HI) cc0[15:8] <= wd;
      if (cap_evt) cc0 <= cnt;
      if (rd_issue && idx == `TMC_IDX_CNT_LO) cnt_hi_buf <= cnt[15:8];
      if (wr_irq_stat) irq_stat <= irq_stat & ~wd[1:0];
      if (ch0_evt) irq_stat[0] <= 1'b1;
      if (ovf_evt) irq_stat[1] <= 1'b1;
    end
  end

  // ========================================================================
  // interrupt output: channel 0 also needs its own mask bit
  wire next_irq = (irq_stat[0] & irq_mask[0] & cctl0[`TMC_CC_IM])
                | (irq_stat[1] & irq_mask[1]);

  // ========================================================================
  // read mux and acknowledge
  reg [7:0] rdata;
  always @* begin
    case (idx)
      `TMC_IDX_CTL: rdata = ctl;
      `TMC_IDX_CCTL0: rdata = cctl0;
      `TMC_IDX_CNT_LO: rdata = cnt[7:0];
      `TMC_IDX_CNT_HI: rdata = cnt_hi_buf;
      `TMC_IDX_CC0_LO: rdata = cc0[7:0];
      `TMC_IDX_CC0_HI: rdata = cc0[15:8];
      `TMC_IDX_RFMASK: rdata = rfmask;
      `TMC_IDX_IRQ_STAT: rdata = {6'h00, irq_stat};
      `TMC_IDX_IRQ_MASK: rdata = {6'h00, irq_mask};
      default: rdata = 8'h00;
    endcase
  end

  always @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
      CPU_TIMER_IRQ_FLAG <= 1'b0;
    end else begin
      WB_ACK_O <= req & ~WB_ACK_O;
      if (rd_issue)
        WB_DAT_O <= {24'h000000, rdata};
      CPU_TIMER_IRQ_FLAG <= next_irq;
    end
  end
endmodule // tmc_top

// file: verification/tmc_top_properties.sv
`timescale 1ns/1ps
module tmc_props (
  input wire CORE_CLK, // clock
  input wire RESET, // reset
  input wire WB_CYC_I, // cycle
  input wire WB_STB_I, // strobe
  input wire WB_WE_I, // write
  input wire [9:0] WB_ADR_I, // address
  input wire [3:0] WB_SEL_I, // lanes
  input wire [31:0] WB_DAT_I, // wdata
  input wire [31:0] WB_DAT_O, // rdata
  input wire WB_ACK_O, // ack
  input wire CH0_OUT, // output
  input wire CPU_TIMER_IRQ_FLAG // irq
);
  // ==========================================================
  // shadows of the plain read/write fields
  wire [7:0] idx = WB_ADR_I[9:2];
  wire wr = WB_ACK_O && WB_WE_I && WB_SEL_I[0];
  wire rd = WB_ACK_O && !WB_WE_I;
  reg [7:0] sh_cc;
  reg [3:0] sh_ctl;
  reg [1:0] sh_msk;
  reg cnt_zero;
  always @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      sh_cc <= 8'h40;
      sh_ctl <= 4'h0;
      sh_msk <= 2'h3;
      cnt_zero <= 1'b1;
    end else if (wr) begin
      if (idx == 8'he5) sh_cc <= WB_DAT_I[7:0];
      if (idx == 8'hf2) sh_msk <= WB_DAT_I[1:0];
      // counter known zero only while suspended after a clear
      if (idx == 8'he2 && sh_ctl[1:0] == 2'h0) cnt_zero <= 1'b1;
      if (idx == 8'he4) begin
        sh_ctl <= WB_DAT_I[3:0];
        if (WB_DAT_I[1:0] != 2'h0) cnt_zero <= 1'b0;
      end
    end
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  property p_ack_ans;
    $rose(WB_STB_I) && WB_CYC_I && !WB_ACK_O |=> WB_ACK_O;
  endproperty
  a_ack_ans: assert property (p_ack_ans) else $error("ack missing");
  property p_ack_one;
    WB_ACK_O |=> !WB_ACK_O;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_dat_hi;
    rd |-> WB_DAT_O[31:8] == 24'h000000;
  endproperty
  a_dat_hi: assert property (p_dat_hi) else $error("upper read bits");
  property p_unmap;
    rd && idx == 8'h00 |-> WB_DAT_O == 32'h00000000;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_cctl;
    rd && idx == 8'he5 |-> WB_DAT_O[7:0] == sh_cc;
  endproperty
  a_cctl: assert property (p_cctl) else $error("cctl0 read");
  property p_ctl;
    rd && idx == 8'he4 |-> WB_DAT_O[3:0] == sh_ctl;
  endproperty
  a_ctl: assert property (p_ctl) else $error("ctl field read");
  property p_msk;
    rd && idx == 8'hf2 |-> WB_DAT_O[1:0] == sh_msk;
  endproperty
  a_msk: assert property (p_msk) else $error("mask read");
  property p_cnt;
    rd && idx == 8'he2 && cnt_zero |-> WB_DAT_O[7:0] == 8'h00;
  endproperty
  a_cnt: assert property (p_cnt) else $error("counter not held");
  c_irq: cover property (CPU_TIMER_IRQ_FLAG);
  c_out: cover property (CH0_OUT);
  c_clr: cover property (wr && idx == 8'he2);
endmodule // tmc_props
bind tmc_top tmc_props u_props (.CORE_CLK(CORE_CLK), .RESET(RESET),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
  .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
  .CH0_OUT(CH0_OUT), .CPU_TIMER_IRQ_FLAG(CPU_TIMER_IRQ_FLAG));

// file: verification/test_tmc_top.sv
`timescale 1ns/1ps
module test_tmc_top;
  reg clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  reg tk = 1'b0, cap = 1'b0;
  reg [9:0] adr = 10'h000;
  reg [31:0] dat = 32'h0;
  reg [7:0] rf = 8'h00, q;
  reg [1:0] chev = 2'h0;
  wire [31:0] dout;
  wire ack, out0, irq;
  integer n_errors = 0, n_checks = 0, i;
  always #50 clk = ~clk;
  tmc_top dut (.CORE_CLK(clk), .RESET(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'h1), .WB_DAT_I(dat), .WB_DAT_O(dout), .WB_ACK_O(ack),
    .TICK(tk), .CAPTURE_IN(cap), .RADIO_EVENTS(rf), .CHAN_EVENTS(chev), .CH0_OUT(out0),
    .CPU_TIMER_IRQ_FLAG(irq));
  // ==========================================================
  // shared tasks
  task report_and_stop;
    begin
      if (n_errors == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        $display("[ERR] %s exp %h got %h", nm, e, g);
        n_errors = n_errors + 1;
      end
    end
  endtask
  task bus(input w, input [7:0] a, input [7:0] d);
    integer k;
    begin
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {a, 2'b00};
      dat <= {24'h0, d};
      k = 0;
      do begin
        @(posedge clk);
        #1;
        k = k + 1;
      end while (ack !== 1'b1 && k < 20);
      if (ack !== 1'b1) begin
        n_errors = n_errors + 1;
        report_and_stop;
      end
      @(posedge clk);
      q = dout[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    bus(1'b1, a, d);
  endtask
  task rc(input [7:0] a, input [7:0] e, input string nm);
    begin
      bus(1'b0, a, 8'h00);
      chk(nm, e, q);
    end
  endtask
  task pulse(input integer n);
    repeat (n) begin
      @(posedge clk);
      tk <= 1'b1;
      @(posedge clk);
      tk <= 1'b0;
    end
  endtask
  task settle;
    begin
      repeat (8) @(posedge clk);
      #1;
    end
  endtask
  task restart(input [7:0] c, input [7:0] m);
    begin
      wr(8'he4, 8'h00);
      wr(8'he2, 8'h5a);
      wr(8'hda, c);
      wr(8'hdb, 8'h00);
      wr(8'he4, m);
    end
  endtask
  // ==========================================================
  // scenarios
  task t_reset;
    begin
      rc(8'he4, 8'h00, "ctl");
      rc(8'he5, 8'h40, "cctl0");
      rc(8'hf2, 8'h03, "irqmask");
      rc(8'he2, 8'h00, "cnt");
      rc(8'h00, 8'h00, "unmapped");
    end
  endtask
  task t_div;
    integer tk_n[4], adv[4];
    begin
      // the prescaler keeps its count across divider writes, so three ticks at /8
      // reach the tap only because five ticks went before
      tk_n = '{2, 3, 64, 128};
      adv = '{2, 1, 2, 1};
      for (i = 0; i < 4; i = i + 1) begin
        restart(8'h00, {4'h0, i[1:0], 2'b01});
        pulse(tk_n[i]);
        wr(8'he4, {4'h0, i[1:0], 2'b00});
        pulse(3);
        rc(8'he2, adv[i], "divcnt");
      end
    end
  endtask
  task t_flags;
    begin
      restart(8'h03, 8'h02);
      pulse(4);
      rc(8'he2, 8'h00, "modcnt");
      rc(8'he4, 8'h12, "ovf");
      chk("irq", 1, irq);
      wr(8'he4, 8'hf0);
      rc(8'he4, 8'h10, "wr1");
      wr(8'hf2, 8'h01);
      settle;
      chk("irqmasked", 0, irq);
      @(posedge clk);
      chev <= 2'h3;
      @(posedge clk);
      chev <= 2'h0;
      rc(8'he4, 8'hd0, "chflags");
      wr(8'he4, 8'h00);
      rc(8'he4, 8'h00, "clr0");
      wr(8'hf1, 8'h02);
      wr(8'hf2, 8'h03);
      settle;
      chk("irqclr", 0, irq);
    end
  endtask
  task t_updown;
    reg [7:0] seq[4];
    begin
      seq = '{8'h01, 8'h02, 8'h01, 8'h00};
      restart(8'h02, 8'h03);
      for (i = 0; i < 4; i = i + 1) begin
        pulse(1);
        rc(8'he2, seq[i], "updn");
      end
      rc(8'he4, 8'h03, "noovf");
      pulse(1);
      rc(8'he2, 8'h01, "turn");
      rc(8'he4, 8'h13, "turnovf");
    end
  endtask
  task t_compare;
    reg [2:0] act[5];
    reg exp_o[5];
    begin
      act = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h2};
      exp_o = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
      restart(8'h02, 8'h02);
      for (i = 0; i < 5; i = i + 1) begin
        wr(8'he5, {2'b01, act[i], 3'b100});
        pulse(3);
        settle;
        chk("ch0out", exp_o[i], out0);
      end
      wr(8'he5, 8'h64);
      pulse(1);
      settle;
      chk("zeroset", 1, out0);
      pulse(2);
      settle;
      chk("clrup", 0, out0);
      wr(8'he5, 8'h5c);
      pulse(3);
      settle;
      chk("setup", 1, out0);
      pulse(1);
      settle;
      chk("zeroclr", 0, out0);
      rc(8'he4, 8'h32, "cmpflag");
    end
  endtask
  task t_capture;
    begin
      restart(8'h00, 8'h01);
      wr(8'he5, 8'h41);
      wr(8'hf1, 8'h03);
      settle;
      chk("irqidle", 0, irq);
      pulse(5);
      @(posedge clk);
      cap <= 1'b1;
      settle;
      rc(8'hda, 8'h05, "capval");
      rc(8'he4, 8'h21, "capflag");
      chk("capirq", 1, irq);
      wr(8'he5, 8'h01);
      settle;
      chk("imoff", 0, irq);
      pulse(2);
      @(posedge clk);
      cap <= 1'b0;
      settle;
      rc(8'hda, 8'h05, "nofall");
      wr(8'hf0, 8'h01);
      wr(8'he5, 8'h81);
      @(posedge clk);
      rf <= 8'h01;
      @(posedge clk);
      rf <= 8'h00;
      settle;
      rc(8'hda, 8'h07, "radiocap");
      wr(8'he5, 8'h02);
      pulse(1);
      @(posedge clk);
      cap <= 1'b1;
      settle;
      rc(8'hda, 8'h07, "norise");
      @(posedge clk);
      cap <= 1'b0;
      settle;
      rc(8'hda, 8'h08, "fallcap");
      wr(8'he5, 8'h03);
      pulse(1);
      @(posedge clk);
      cap <= 1'b1;
      settle;
      rc(8'hda, 8'h09, "bothcap");
    end
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_div;
    t_flags;
    t_updown;
    t_compare;
    t_capture;
    report_and_stop;
  end
endmodule // test_tmc_top
